// ---- logic/bccr_defs.vh ----
// constants for the bridge chip control register bank
`ifndef BCCR_DEFS_VH
`define BCCR_DEFS_VH

// dword byte addresses in configuration space
`define BCCR_OFF_BRIDGE_CTL 8'h3c
`define BCCR_OFF_SUBSYS 8'h40
`define BCCR_OFF_CHIP_CTL 8'h44
`define BCCR_ADDR_W 8

// bridge control upper word, positions within the dword
`define BCCR_BC_SEC_RST 22
`define BCCR_BC_PRI_TMO 24
`define BCCR_BC_SEC_TMO 25
`define BCCR_BC_TMO_STS 26
`define BCCR_BC_TMO_SERR 27

// chip control, positions within the dword
`define BCCR_CC_WR_DISC 1
`define BCCR_CC_UP_PF_DIS 4
`define BCCR_CC_CHIP_RST 8

// subsystem word lanes
`define BCCR_SV_LO 15
`define BCCR_SI_LO 16
`define BCCR_SI_HI 31

// reset values
`define BCCR_RST_IDENT 16'h0000
`define BCCR_RST_BIT 1'b0

// timeout limits in pci clocks (2^15 and 2^10)
`define BCCR_TMO_LONG 16'h8000
`define BCCR_TMO_SHORT 16'h0400
`define BCCR_TMO_W 16

// chip reset interval in clocks
`define BCCR_CHIP_RST_CLKS 4'h8
`define BCCR_CRST_W 4

// pci bus commands on the upstream read path
`define BCCR_CMD_MEM_RD 4'h6
`define BCCR_CMD_MEM_RD_MULT 4'hc
`define BCCR_CMD_MEM_RD_LINE 4'he

// number of delayed transaction channels: 0 primary, 1 secondary
`define BCCR_NCHAN 2

`endif

// ---- logic/bccr_regs.v ----
// bridge chip control registers with delayed transaction timeouts
`timescale 1ns/1ns
`default_nettype none
`include "bccr_defs.vh"

module bccr_regs #(
	parameter [`BCCR_TMO_W-1:0] TMO_LONG = `BCCR_TMO_LONG,
	parameter [`BCCR_TMO_W-1:0] TMO_SHORT = `BCCR_TMO_SHORT,
	parameter [`BCCR_CRST_W-1:0] CHIP_RST_CLKS = `BCCR_CHIP_RST_CLKS
) (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_cfg_wr,
	input wire i_cfg_rd,
	input wire [`BCCR_ADDR_W-1:0] i_cfg_addr,
	input wire [3:0] i_cfg_be_n,
	input wire [31:0] i_cfg_wdata,
	output reg [31:0] o_cfg_rdata,
	output reg o_cfg_rvalid,
	input wire i_serr_enable,
	input wire [`BCCR_NCHAN-1:0] i_dly_head,
	input wire [`BCCR_NCHAN-1:0] i_dly_repeat,
	output reg [`BCCR_NCHAN-1:0] o_dly_discard,
	output reg o_primary_system_error_out_n,
	output reg o_wr_disc_cacheline,
	input wire i_up_rd_valid,
	input wire [3:0] i_up_rd_cmd,
	output reg o_up_rd_single,
	output reg o_up_rd_prefetch,
	output reg o_chip_rst,
	output reg o_sec_domain_rst,
	output reg o_sec_bus_rst_n
);

	reg [15:0] sub_vendor_q;
	reg [15:0] sub_vendor_d;
	reg [15:0] sub_ident_q;
	reg [15:0] sub_ident_d;
	reg wr_disc_q;
	reg wr_disc_d;
	reg pf_dis_q;
	reg pf_dis_d;
	reg sec_rst_q;
	reg sec_rst_d;
	reg pri_tmo_q;
	reg pri_tmo_d;
	reg sec_tmo_q;
	reg sec_tmo_d;
	reg tmo_sts_q;
	reg tmo_sts_d;
	reg tmo_serr_q;
	reg tmo_serr_d;
	reg [`BCCR_CRST_W-1:0] crst_cnt_q;
	reg [`BCCR_CRST_W-1:0] crst_cnt_d;
	reg crst_q;
	reg crst_d;
	reg [31:0] rdata_d;
	reg [31:0] be_mask;
	wire [`BCCR_NCHAN-1:0] tsel;
	wire [`BCCR_NCHAN-1:0] disc_d;
	wire any_disc;
	wire hit_bc;
	wire hit_ss;
	wire hit_cc;
	wire cfg_we;

	// writes during chip reset are dropped; the registers are held at reset
	assign cfg_we = i_cfg_wr & ~crst_q;
	// exact dword match; other addresses ignore writes and read zero
	assign hit_bc = (i_cfg_addr == `BCCR_OFF_BRIDGE_CTL);
	assign hit_ss = (i_cfg_addr == `BCCR_OFF_SUBSYS);
	assign hit_cc = (i_cfg_addr == `BCCR_OFF_CHIP_CTL);
	// select bits are read live every clock
	assign tsel = {sec_tmo_q, pri_tmo_q};
	assign any_disc = |disc_d;

	// one timeout counter per delayed transaction queue
	genvar ch;
	generate
		for (ch = 0; ch < `BCCR_NCHAN; ch = ch + 1) begin : g_tmo
			reg [`BCCR_TMO_W-1:0] cnt_q;
			reg done_q;
			reg disc_r;
			wire [`BCCR_TMO_W-1:0] lim;
			assign lim = tsel[ch] ? TMO_SHORT : TMO_LONG;
			assign disc_d[ch] = disc_r;
			always @(*) begin
				disc_r = 1'b0;
				// at or past the limit: a select change must not wrap
				if (i_dly_head[ch] && !i_dly_repeat[ch] && !done_q &&
				    (cnt_q >= lim - {{(`BCCR_TMO_W-1){1'b0}}, 1'b1})) begin
					disc_r = 1'b1;
				end
			end
			always @(posedge i_core_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					cnt_q <= {`BCCR_TMO_W{1'b0}};
					done_q <= 1'b0;
				end else if (crst_q || !i_dly_head[ch]) begin
					// idle until the completion reaches the head
					cnt_q <= {`BCCR_TMO_W{1'b0}};
					done_q <= 1'b0;
				end else if (i_dly_repeat[ch] || disc_r) begin
					// a repeat or a discard ends this completion's wait
					cnt_q <= {`BCCR_TMO_W{1'b0}};
					done_q <= 1'b1;
				end else if (!done_q) begin
					cnt_q <= cnt_q + {{(`BCCR_TMO_W-1){1'b0}}, 1'b1};
				end
			end
		end
	endgenerate

	// byte-lane mask from active low enables
	always @(*) begin
		be_mask = {{8{~i_cfg_be_n[3]}}, {8{~i_cfg_be_n[2]}},
			{8{~i_cfg_be_n[1]}}, {8{~i_cfg_be_n[0]}}};
	end

	// next register values
	always @(*) begin
		sub_vendor_d = sub_vendor_q;
		sub_ident_d = sub_ident_q;
		wr_disc_d = wr_disc_q;
		pf_dis_d = pf_dis_q;
		sec_rst_d = sec_rst_q;
		pri_tmo_d = pri_tmo_q;
		sec_tmo_d = sec_tmo_q;
		tmo_sts_d = tmo_sts_q;
		tmo_serr_d = tmo_serr_q;
		crst_d = crst_q;
		crst_cnt_d = crst_cnt_q;
		// vendor ident in lanes zero and one, subsystem ident in two, three
		if (cfg_we && hit_ss) begin
			if (!i_cfg_be_n[0])
				sub_vendor_d[7:0] = i_cfg_wdata[7:0];
			if (!i_cfg_be_n[1])
				sub_vendor_d[15:8] = i_cfg_wdata[15:8];
			if (!i_cfg_be_n[2])
				sub_ident_d[7:0] = i_cfg_wdata[23:16];
			if (!i_cfg_be_n[3])
				sub_ident_d[15:8] = i_cfg_wdata[31:24];
		end
		if (cfg_we && hit_cc && !i_cfg_be_n[0]) begin
			wr_disc_d = i_cfg_wdata[`BCCR_CC_WR_DISC];
			pf_dis_d = i_cfg_wdata[`BCCR_CC_UP_PF_DIS];
		end
		// bridge control upper word: lane two sec reset, lane three timeouts
		if (cfg_we && hit_bc && !i_cfg_be_n[2])
			sec_rst_d = i_cfg_wdata[`BCCR_BC_SEC_RST];
		if (cfg_we && hit_bc && !i_cfg_be_n[3]) begin
			pri_tmo_d = i_cfg_wdata[`BCCR_BC_PRI_TMO];
			sec_tmo_d = i_cfg_wdata[`BCCR_BC_SEC_TMO];
			tmo_serr_d = i_cfg_wdata[`BCCR_BC_TMO_SERR];
			if (i_cfg_wdata[`BCCR_BC_TMO_STS])
				tmo_sts_d = 1'b0;
		end
		// a discard in the clearing cycle still sets the flag
		if (any_disc)
			tmo_sts_d = 1'b1;
		// chip reset start: write one to the bit in lane one
		if (cfg_we && hit_cc && !i_cfg_be_n[1] &&
		    i_cfg_wdata[`BCCR_CC_CHIP_RST]) begin
			crst_d = 1'b1;
			crst_cnt_d = CHIP_RST_CLKS - {{(`BCCR_CRST_W-1){1'b0}}, 1'b1};
		end
		// registers take reset values from the clock after the bit sets
		if (crst_q) begin
			// configuration held at reset values for the interval, except the secondary reset bit, held at one
			sub_vendor_d = `BCCR_RST_IDENT;
			sub_ident_d = `BCCR_RST_IDENT;
			wr_disc_d = `BCCR_RST_BIT;
			pf_dis_d = `BCCR_RST_BIT;
			pri_tmo_d = `BCCR_RST_BIT;
			sec_tmo_d = `BCCR_RST_BIT;
			tmo_sts_d = `BCCR_RST_BIT;
			tmo_serr_d = `BCCR_RST_BIT;
			sec_rst_d = 1'b1;
			if (crst_cnt_q == {`BCCR_CRST_W{1'b0}})
				crst_d = 1'b0;
			else
				crst_cnt_d = crst_cnt_q - {{(`BCCR_CRST_W-1){1'b0}}, 1'b1};
		end
	end

	// read mux; unmapped and reserved bits return zero
	always @(*) begin
		rdata_d = 32'h0000_0000;
		if (hit_ss) begin
			rdata_d[`BCCR_SV_LO:0] = sub_vendor_q;
			rdata_d[`BCCR_SI_HI:`BCCR_SI_LO] = sub_ident_q;
		end else if (hit_cc) begin
			rdata_d[`BCCR_CC_WR_DISC] = wr_disc_q;
			rdata_d[`BCCR_CC_UP_PF_DIS] = pf_dis_q;
			rdata_d[`BCCR_CC_CHIP_RST] = crst_q;
		end else if (hit_bc) begin
			// lower bridge control bits live elsewhere and read zero here
			rdata_d[`BCCR_BC_SEC_RST] = sec_rst_q;
			rdata_d[`BCCR_BC_PRI_TMO] = pri_tmo_q;
			rdata_d[`BCCR_BC_SEC_TMO] = sec_tmo_q;
			rdata_d[`BCCR_BC_TMO_STS] = tmo_sts_q;
			rdata_d[`BCCR_BC_TMO_SERR] = tmo_serr_q;
		end
		rdata_d = rdata_d & be_mask;
	end

	// register state
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sub_vendor_q <= `BCCR_RST_IDENT;
			sub_ident_q <= `BCCR_RST_IDENT;
			wr_disc_q <= `BCCR_RST_BIT;
			pf_dis_q <= `BCCR_RST_BIT;
			sec_rst_q <= `BCCR_RST_BIT;
			pri_tmo_q <= `BCCR_RST_BIT;
			sec_tmo_q <= `BCCR_RST_BIT;
			tmo_sts_q <= `BCCR_RST_BIT;
			tmo_serr_q <= `BCCR_RST_BIT;
			crst_q <= 1'b0;
			crst_cnt_q <= {`BCCR_CRST_W{1'b0}};
		end else begin
			sub_vendor_q <= sub_vendor_d;
			sub_ident_q <= sub_ident_d;
			wr_disc_q <= wr_disc_d;
			pf_dis_q <= pf_dis_d;
			sec_rst_q <= sec_rst_d;
			pri_tmo_q <= pri_tmo_d;
			sec_tmo_q <= sec_tmo_d;
			tmo_sts_q <= tmo_sts_d;
			tmo_serr_q <= tmo_serr_d;
			crst_q <= crst_d;
			crst_cnt_q <= crst_cnt_d;
		end
	end

	// read answer one clock after the request
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cfg_rdata <= 32'h0000_0000;
			o_cfg_rvalid <= 1'b0;
		end else begin
			o_cfg_rvalid <= i_cfg_rd;
			// zero between reads so an idle bus carries no stale data
			o_cfg_rdata <= i_cfg_rd ? rdata_d : 32'h0000_0000;
		end
	end

	// steering and reset outputs, all registered
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_dly_discard <= {`BCCR_NCHAN{1'b0}};
			o_primary_system_error_out_n <= 1'b1;
			o_wr_disc_cacheline <= 1'b0;
			o_up_rd_single <= 1'b0;
			o_up_rd_prefetch <= 1'b0;
			o_chip_rst <= 1'b0;
			o_sec_domain_rst <= 1'b0;
			o_sec_bus_rst_n <= 1'b1;
		end else begin
			o_dly_discard <= disc_d;
			// one low clock per discard, gated by both enables
			// discards on both channels together share one low clock
			o_primary_system_error_out_n <=
				~(any_disc & tmo_serr_q & i_serr_enable);
			o_wr_disc_cacheline <= wr_disc_q;
			// plain reads go single-dword only when prefetch is disabled
			o_up_rd_single <= i_up_rd_valid & pf_dis_q &
				(i_up_rd_cmd == `BCCR_CMD_MEM_RD);
			// line and multiple reads prefetch whatever the disable bit says
			o_up_rd_prefetch <= i_up_rd_valid &
				(((i_up_rd_cmd == `BCCR_CMD_MEM_RD) & ~pf_dis_q) |
				(i_up_rd_cmd == `BCCR_CMD_MEM_RD_LINE) |
				(i_up_rd_cmd == `BCCR_CMD_MEM_RD_MULT));
			o_chip_rst <= crst_q;
			// secondary side only; primary and config not touched here
			o_sec_domain_rst <= sec_rst_q | crst_q;
			o_sec_bus_rst_n <= ~(sec_rst_q | crst_q);
		end
	end

endmodule // bccr_regs
`default_nettype wire

// ---- sim/bccr_host.sv ----
// configuration cycle host on the primary side
`timescale 1ns/1ns
`default_nettype none
module bccr_host (
	input wire logic i_core_clk,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [3:0] o_be_n,
	output logic [31:0] o_wdata
);
	initial begin
		o_wr = 0;
		o_rd = 0;
		o_addr = 8'h00;
		o_be_n = 4'hf;
		o_wdata = 32'h0;
	end
	// called at a falling edge; one dword per strobe
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d);
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_be_n = b;
		o_wdata = d;
		@(negedge i_core_clk);
	endtask
	// released lines show no stale value
	task automatic idle;
		o_wr = 0;
		o_rd = 0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
		@(negedge i_core_clk);
	endtask
endmodule // bccr_host
`default_nettype wire

// ---- sim/bccr_monitor.sv ----
// port assertions for the chip control register bank
`timescale 1ns/1ns
`default_nettype none
module bccr_monitor (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_cfg_rd,
	input wire [7:0] i_cfg_addr,
	input wire [31:0] o_cfg_rdata,
	input wire o_cfg_rvalid,
	input wire [1:0] i_dly_head,
	input wire [1:0] o_dly_discard,
	input wire o_primary_system_error_out_n,
	input wire i_up_rd_valid,
	input wire [3:0] i_up_rd_cmd,
	input wire o_up_rd_single,
	input wire o_up_rd_prefetch,
	input wire o_chip_rst,
	input wire o_sec_domain_rst,
	input wire o_sec_bus_rst_n
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	a_rd_answer: assert property (i_cfg_rd |=> o_cfg_rvalid)
		else $error("read not answered");
	a_rd_idle: assert property (!o_cfg_rvalid |-> o_cfg_rdata == 32'h0)
		else $error("rdata not zero while idle");
	a_rd_unmapped: assert property (i_cfg_rd && i_cfg_addr != 8'h3c
		&& i_cfg_addr != 8'h40 && i_cfg_addr != 8'h44 |=> o_cfg_rdata == 0)
		else $error("unmapped read not zero");
	a_serr_cause: assert property (!o_primary_system_error_out_n
		|-> o_dly_discard != 2'b00) else $error("serr without discard");
	a_discard_once: assert property ((o_dly_discard
		& $past(o_dly_discard)) == 2'b00) else $error("discard held");
	a_discard_head: assert property ((o_dly_discard
		& ~$past(i_dly_head)) == 2'b00) else $error("discard without head");
	a_chip_len: assert property ($rose(o_chip_rst)
		|-> o_chip_rst[*8] ##1 !o_chip_rst) else $error("chip reset length");
	a_chip_sec: assert property (o_chip_rst |-> !o_sec_bus_rst_n)
		else $error("chip reset without secondary reset");
	a_sec_inv: assert property (o_sec_bus_rst_n != o_sec_domain_rst)
		else $error("secondary reset pair disagrees");
	a_single_cmd: assert property (o_up_rd_single
		|-> $past(i_up_rd_valid && i_up_rd_cmd == 4'h6))
		else $error("single without plain read");
	a_line_pf: assert property ($past(i_up_rd_valid &&
		(i_up_rd_cmd == 4'hc || i_up_rd_cmd == 4'he)) |-> o_up_rd_prefetch)
		else $error("line read not prefetched");
endmodule // bccr_monitor
bind bccr_regs bccr_monitor u_mon (.i_core_clk(i_core_clk),
	.i_arst_n(i_arst_n), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
	.o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
	.i_dly_head(i_dly_head), .o_dly_discard(o_dly_discard),
	.o_primary_system_error_out_n(o_primary_system_error_out_n),
	.i_up_rd_valid(i_up_rd_valid), .i_up_rd_cmd(i_up_rd_cmd),
	.o_up_rd_single(o_up_rd_single), .o_up_rd_prefetch(o_up_rd_prefetch),
	.o_chip_rst(o_chip_rst), .o_sec_domain_rst(o_sec_domain_rst),
	.o_sec_bus_rst_n(o_sec_bus_rst_n));
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the chip control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic i_core_clk = 0;
	logic i_arst_n = 0;
	logic i_serr_enable = 0;
	logic [1:0] i_dly_head = 2'h0;
	logic [1:0] i_dly_repeat = 2'h0;
	logic i_up_rd_valid = 0;
	logic [3:0] i_up_rd_cmd = 4'h0;
	wire i_cfg_wr, i_cfg_rd, o_cfg_rvalid, o_serr_n, o_wr_disc;
	wire o_single, o_pf, o_chip_rst, o_sec_dom, o_sec_bus_rst_n;
	wire [7:0] i_cfg_addr;
	wire [3:0] i_cfg_be_n;
	wire [31:0] i_cfg_wdata, o_cfg_rdata;
	wire [1:0] o_dly_discard;
	logic [31:0] exp_q[$];
	logic [31:0] d1, d2;
	logic [3:0] cmd_t[4] = '{4'h6, 4'hc, 4'he, 4'h7};
	int num_errors = 0;
	int comparisons = 0;
	int seed = 22;
	always #20 i_core_clk = ~i_core_clk;
	bccr_host host (.i_core_clk(i_core_clk), .o_wr(i_cfg_wr),
		.o_rd(i_cfg_rd), .o_addr(i_cfg_addr), .o_be_n(i_cfg_be_n),
		.o_wdata(i_cfg_wdata));
	// short counts keep the run brief
	bccr_regs #(.TMO_LONG(16'h0040), .TMO_SHORT(16'h0010),
		.CHIP_RST_CLKS(4'h8)) DUT (.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
		.i_cfg_addr(i_cfg_addr), .i_cfg_be_n(i_cfg_be_n),
		.i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
		.o_cfg_rvalid(o_cfg_rvalid), .i_serr_enable(i_serr_enable),
		.i_dly_head(i_dly_head), .i_dly_repeat(i_dly_repeat),
		.o_dly_discard(o_dly_discard),
		.o_primary_system_error_out_n(o_serr_n),
		.o_wr_disc_cacheline(o_wr_disc), .i_up_rd_valid(i_up_rd_valid),
		.i_up_rd_cmd(i_up_rd_cmd), .o_up_rd_single(o_single),
		.o_up_rd_prefetch(o_pf), .o_chip_rst(o_chip_rst),
		.o_sec_domain_rst(o_sec_dom), .o_sec_bus_rst_n(o_sec_bus_rst_n));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		host.xfer(1, a, b, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] e);
		exp_q.push_back(e);
		host.xfer(0, a, b, 32'h0);
	endtask
	always @(negedge i_core_clk) begin
		if (o_cfg_rvalid === 1'b1)
			check(o_cfg_rdata, exp_q.pop_front(), "rdata");
	end
	task automatic up(input logic dis);
		for (int j = 0; j < 4; j++) begin
			i_up_rd_valid = 1;
			i_up_rd_cmd = cmd_t[j];
			@(negedge i_core_clk);
			check(o_single, dis && j == 0, "single");
			check(o_pf, !(dis && j == 0) && j < 3, "prefetch");
		end
		i_up_rd_valid = 0;
	endtask
	// head held; expect discard after len cycles unless repeated
	task automatic tmo(input int ch, input int len, input int ns,
		input logic rep);
		int k;
		int n;
		k = 0;
		n = 0;
		i_dly_head[ch] = 1;
		i_dly_repeat[ch] = rep;
		for (int c = 1; c <= len + 8; c++) begin
			@(negedge i_core_clk);
			i_dly_repeat[ch] = 0;
			if (o_dly_discard[ch] === 1'b1 && k == 0)
				k = c;
			if (o_serr_n === 1'b0)
				n++;
		end
		i_dly_head[ch] = 0;
		@(negedge i_core_clk);
		check(k, rep ? 0 : len, "discard cycle");
		check(n, ns, "serr count");
	endtask
	initial begin
		#80000;
		num_errors++;
		final_report;
	end
	initial begin
		repeat (20) @(negedge i_core_clk);
		i_arst_n = 1;
		d1 = $random(seed);
		d2 = $random(seed);
		rd(8'h40, 4'h0, 32'h0);
		rd(8'h44, 4'h0, 32'h0);
		rd(8'h3c, 4'h0, 32'h0);
		wr(8'h40, 4'h0, d1);
		wr(8'h40, 4'h3, d2);
		rd(8'h40, 4'h0, {d2[31:16], d1[15:0]});
		rd(8'h40, 4'hc, {16'h0, d1[15:0]});
		wr(8'h48, 4'h0, d1);
		rd(8'h48, 4'h0, 32'h0);
		wr(8'h44, 4'h0, 32'hffff_feff);
		rd(8'h44, 4'h0, 32'h12);
		host.idle;
		check(o_wr_disc, 1, "write disconnect");
		up(1);
		wr(8'h44, 4'h0, 32'h2);
		host.idle;
		up(0);
		wr(8'h3c, 4'h0, 32'h0900_0000);
		host.idle;
		i_serr_enable = 1;
		tmo(0, 16, 1, 0);
		rd(8'h3c, 4'h0, 32'h0d00_0000);
		wr(8'h3c, 4'h7, 32'h0900_0000);
		rd(8'h3c, 4'h0, 32'h0d00_0000);
		wr(8'h3c, 4'h7, 32'h0c00_0000);
		rd(8'h3c, 4'h0, 32'h0800_0000);
		host.idle;
		tmo(0, 64, 0, 1);
		wr(8'h3c, 4'h7, 32'h0200_0000);
		host.idle;
		tmo(1, 16, 0, 0);
		wr(8'h3c, 4'h7, 32'h0800_0000);
		host.idle;
		i_serr_enable = 0;
		tmo(1, 64, 0, 0);
		tmo(0, 64, 0, 0);
		wr(8'h44, 4'hd, 32'h100);
		rd(8'h44, 4'hd, 32'h100);
		check(o_chip_rst, 1, "chip reset out");
		wr(8'h40, 4'h0, d1);
		host.idle;
		repeat (10) @(negedge i_core_clk);
		check(o_chip_rst, 0, "chip reset end");
		check(o_wr_disc, 0, "write disconnect");
		rd(8'h44, 4'h0, 32'h0);
		rd(8'h40, 4'h0, 32'h0);
		rd(8'h3c, 4'h0, 32'h0040_0000);
		host.idle;
		check(o_sec_bus_rst_n, 0, "secondary reset");
		check(o_sec_dom, 1, "secondary domain reset");
		wr(8'h3c, 4'hb, 32'h0);
		host.idle;
		@(negedge i_core_clk);
		check(o_sec_bus_rst_n, 1, "secondary release");
		check(o_sec_dom, 0, "secondary domain release");
		check(exp_q.size(), 0, "reads left");
		final_report;
	end
endmodule // tb_top
`default_nettype wire
